//--- core/rit_pkg.sv
// shared constants for the requester identity tagging block
package rit_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register fields
  localparam int CTL_CLEAR_SEEN_BIT = 0;
  // status register fields
  localparam int STS_HOLD_ID_LSB = 0;
  localparam int STS_HOLD_PAR_BIT = 2;
  localparam int STS_LOAD_SEEN_BIT = 3;
  localparam int STS_ACCEPT_BIT = 4;
  localparam int STS_REMEMBER_BIT = 5;
  // identity hold register reset: identity clear, parity set
  localparam logic [1:0] HOLD_ID_RESET = 2'h0;
  localparam logic HOLD_PAR_RESET = 1'b1;
  // inbound data bit carrying channel end
  localparam int CHANNEL_END_BIT = 4;
  localparam logic [7:0] STATUS_ALL_ZERO = 8'h00;
  // condition code sent with release
  localparam logic [1:0] CONDITION_CODE_VALUE_RELEASE = 2'h0;
  localparam logic [1:0] TAG_IDLE = 2'h0;
endpackage : rit_pkg

//--- core/rit_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
// axi4-lite slave: one write and one read at a time, fixed latency
module rit_axil_slave (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // write address and data
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  // write response
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // read channels
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // register file side
  output logic wr_pulse_out,
  output logic [7:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  output logic [7:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_hit_in,
  input wire logic wr_hit_in
);
  typedef struct packed {
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic wr_pulse;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } rit_axil_state_t;

  rit_axil_state_t st;
  rit_axil_state_t next_st;

  // ready is only offered while the holding slot is empty
  assign awready_out = st.aw_rdy;
  assign wready_out = st.w_rdy;
  assign arready_out = st.ar_rdy;
  assign bvalid_out = st.bvalid;
  assign bresp_out = st.bresp;
  assign rvalid_out = st.rvalid;
  assign rdata_out = st.rdata;
  assign rresp_out = st.rresp;
  assign wr_pulse_out = st.wr_pulse;
  assign wr_addr_out = st.awaddr;
  assign wr_data_out = st.wdata;
  assign wr_strb_out = st.wstrb;
  assign rd_addr_out = araddr_in;

  // address and data may come in either order; the write fires once both sit
  always_comb begin
    next_st = st;
    next_st.wr_pulse = 1'b0;
    if (awvalid_in && !st.aw_full) begin
      next_st.aw_full = 1'b1;
      next_st.awaddr = awaddr_in;
    end
    if (wvalid_in && !st.w_full) begin
      next_st.w_full = 1'b1;
      next_st.wdata = wdata_in;
      next_st.wstrb = wstrb_in;
    end
    if (st.aw_full && st.w_full && !st.bvalid && !st.wr_pulse) begin
      next_st.wr_pulse = 1'b1;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_hit_in ? rit_pkg::RESP_OKAY : rit_pkg::RESP_SLVERR;
    end
    if (st.bvalid && bready_in) begin
      next_st.bvalid = 1'b0;
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
    end
    if (arvalid_in && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_hit_in ? rd_data_in : 32'h0000_0000;
      next_st.rresp = rd_hit_in ? rit_pkg::RESP_OKAY : rit_pkg::RESP_SLVERR;
    end else if (st.rvalid && rready_in) begin
      next_st.rvalid = 1'b0;
    end
    // readies kept in flops so the bus sees no gate between flop and pin
    next_st.aw_rdy = !next_st.aw_full;
    next_st.w_rdy = !next_st.w_full;
    next_st.ar_rdy = !next_st.rvalid;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule // rit_axil_slave
`default_nettype wire

//--- core/rit_start_accept.sv
`timescale 1ns/1ns
`default_nettype none
// start-i/o accept latch and remembered-start latch
module rit_start_accept (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // channel sequencing
  input wire logic start_io_in,
  input wire logic sequence_one_in,
  input wire logic sequence_five_in,
  input wire logic status_in_in,
  input wire logic timing_pulse_two_in,
  input wire logic [7:0] status_byte_in,
  input wire logic chain_command_first_stage_in,
  input wire logic [7:0] inbound_data_in,
  // latch outputs
  output logic accept_out,
  output logic remember_out
);
  typedef struct packed {
    logic accept;
    logic remember;
    logic start_d;
  } rit_sa_state_t;

  rit_sa_state_t st;
  rit_sa_state_t next_st;
  logic set_status_ok;
  logic set_cmd_immediate;

  assign accept_out = st.accept;
  assign remember_out = st.remember;

  // device free: status all zero in sequence one at timing pulse two
  assign set_status_ok = start_io_in && sequence_one_in && !sequence_five_in && status_in_in &&
                         timing_pulse_two_in && (status_byte_in == rit_pkg::STATUS_ALL_ZERO);
  // command immediate: channel end on inbound data during first chain stage
  assign set_cmd_immediate = start_io_in && chain_command_first_stage_in &&
                             inbound_data_in[rit_pkg::CHANNEL_END_BIT];

  // accept holds while start-i/o stays active; remembered start lives from start until release, or until start-i/o drops if that comes first
  always_comb begin
    next_st = st;
    next_st.start_d = start_io_in;
    next_st.accept = set_status_ok || set_cmd_immediate || (st.accept && start_io_in);
    if (!start_io_in || st.accept) begin
      next_st.remember = 1'b0;
    end else if (!st.start_d) begin
      next_st.remember = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // rit_start_accept
`default_nettype wire

//--- core/rit_top.sv
`timescale 1ns/1ns
`default_nettype none
module rit_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // processor side identity lines
  input wire logic [1:0] originator_identity_in,
  input wire logic originator_identity_parity_in,
  // channel sequencing
  input wire logic initial_program_load_setup_in,
  input wire logic start_io_in,
  input wire logic sequence_one_in,
  input wire logic sequence_five_in,
  input wire logic status_in_in,
  input wire logic timing_pulse_two_in,
  input wire logic timing_pulse_four_in,
  input wire logic [7:0] status_byte_in,
  input wire logic chain_command_first_stage_in,
  input wire logic [7:0] inbound_data_in,
  // storage cycle latches
  input wire logic storage_request_latch_in,
  input wire logic interrupt_storage_request_latch_in,
  input wire logic logout_inhibit_in,
  input wire logic fixed_address_latch_in,
  // storage controller tag lines
  output logic [1:0] request_owner_tag_out,
  output logic request_owner_tag_parity_out,
  // processor side answer
  output logic release_out,
  output logic [1:0] condition_code_value_out,
  output logic identity_load_enable_out
);
  typedef struct packed {
    logic [1:0] hold_id;
    logic hold_par;
    logic [1:0] tag;
    logic tag_par;
    logic load_seen;
    logic load_en;
    logic release_q;
    logic [1:0] condition_code_value;
  } rit_state_t;

  rit_state_t st;
  rit_state_t next_st;

  // register file wires
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic clear_seen;

  // latch outputs from the start unit
  logic accept_latch;
  logic remember_latch;

  // tag path decode
  logic load_now;
  logic pass_logout;
  logic pass_status_store;
  logic pass_start_fetch;
  logic pass_through;

  rit_axil_slave u_bus (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .wr_pulse_out(wr_pulse),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_hit_in(rd_hit),
    .wr_hit_in(wr_hit)
  );

  rit_start_accept u_start (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_io_in(start_io_in),
    .sequence_one_in(sequence_one_in),
    .sequence_five_in(sequence_five_in),
    .status_in_in(status_in_in),
    .timing_pulse_two_in(timing_pulse_two_in),
    .status_byte_in(status_byte_in),
    .chain_command_first_stage_in(chain_command_first_stage_in),
    .inbound_data_in(inbound_data_in),
    .accept_out(accept_latch),
    .remember_out(remember_latch)
  );

  // register decode; the status word is read only, writes to it answer slverr
  assign wr_hit = (wr_addr == rit_pkg::OFF_CONTROL);
  assign rd_hit = (rd_addr == rit_pkg::OFF_CONTROL) || (rd_addr == rit_pkg::OFF_STATUS);
  assign clear_seen = wr_pulse && wr_hit && wr_strb[0] && wr_data[rit_pkg::CTL_CLEAR_SEEN_BIT];

  // read mux: control reads as zero since its only bit is a strobe
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_addr == rit_pkg::OFF_STATUS) begin
      rd_data[rit_pkg::STS_HOLD_ID_LSB +: 2] = st.hold_id;
      rd_data[rit_pkg::STS_HOLD_PAR_BIT] = st.hold_par;
      rd_data[rit_pkg::STS_LOAD_SEEN_BIT] = st.load_seen;
      rd_data[rit_pkg::STS_ACCEPT_BIT] = accept_latch;
      rd_data[rit_pkg::STS_REMEMBER_BIT] = remember_latch;
    end
  end

  // gating of the load: program-load setup start or accepted start-i/o at pulse two
  assign load_now = initial_program_load_setup_in ||
                    (accept_latch && timing_pulse_two_in && !timing_pulse_four_in);

  // cycles whose tag comes straight from the incoming identity lines
  assign pass_logout = logout_inhibit_in && interrupt_storage_request_latch_in;
  assign pass_status_store = fixed_address_latch_in && interrupt_storage_request_latch_in;
  assign pass_start_fetch = remember_latch && storage_request_latch_in;
  assign pass_through = pass_logout || pass_status_store || pass_start_fetch;

  // next state; tagging runs on its own and feeds nothing back into sequencing
  always_comb begin
    next_st = st;
    next_st.load_en = load_now;
    // hold register captures lines only on a load; a pass-through cycle without a load leaves it unchanged
    if (load_now) begin
      next_st.hold_id = originator_identity_in;
      next_st.hold_par = originator_identity_parity_in;
    end
    // tag selection; parity travels with its bits, the controller checks it
    if (pass_through) begin
      next_st.tag = originator_identity_in;
      next_st.tag_par = originator_identity_parity_in;
    end else if (storage_request_latch_in) begin
      next_st.tag = st.hold_id;
      next_st.tag_par = st.hold_par;
    end else begin
      next_st.tag = rit_pkg::TAG_IDLE;
      next_st.tag_par = 1'b0;
    end
    // release and code zero follow the accept latch
    next_st.release_q = accept_latch;
    next_st.condition_code_value = rit_pkg::CONDITION_CODE_VALUE_RELEASE;
    // sticky load indicator: a new load wins over a software clear
    if (load_now) begin
      next_st.load_seen = 1'b1;
    end else if (clear_seen) begin
      next_st.load_seen = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.hold_id <= rit_pkg::HOLD_ID_RESET;
      st.hold_par <= rit_pkg::HOLD_PAR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign request_owner_tag_out = st.tag;
  assign request_owner_tag_parity_out = st.tag_par;
  assign release_out = st.release_q;
  assign condition_code_value_out = st.condition_code_value;
  assign identity_load_enable_out = st.load_en;

  // ---- assertions ----
  sequence s_status_ok;
    start_io_in && sequence_one_in && !sequence_five_in && status_in_in && timing_pulse_two_in &&
    (status_byte_in == rit_pkg::STATUS_ALL_ZERO);
  endsequence

  sequence s_cmd_immediate;
    start_io_in && chain_command_first_stage_in && inbound_data_in[rit_pkg::CHANNEL_END_BIT];
  endsequence

  property p_accept_set;
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_status_ok or s_cmd_immediate) |=> accept_latch;
  endproperty
  a_accept_set: assert property (p_accept_set)
    else $error("accept latch failed to set");

  property p_release_follows;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(accept_latch) |=> release_out && (condition_code_value_out == 2'h0);
  endproperty
  a_release_follows: assert property (p_release_follows)
    else $error("release with code zero missing after accept");

  property p_load_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
      (accept_latch && timing_pulse_two_in && !timing_pulse_four_in) |=> identity_load_enable_out;
  endproperty
  a_load_gate: assert property (p_load_gate)
    else $error("load enable missing at pulse two");

  property p_no_load_at_pulse_four;
    @(posedge clk_in) disable iff (!rst_n_in)
      (timing_pulse_four_in && !initial_program_load_setup_in) |=> !identity_load_enable_out;
  endproperty
  a_no_load_at_pulse_four: assert property (p_no_load_at_pulse_four)
    else $error("load enable active during pulse four");

  property p_program_load_capture;
    @(posedge clk_in) disable iff (!rst_n_in)
      initial_program_load_setup_in |=> (st.hold_id == $past(originator_identity_in)) &&
                                        (st.hold_par == $past(originator_identity_parity_in));
  endproperty
  a_program_load_capture: assert property (p_program_load_capture)
    else $error("identity not captured at program-load setup");

  property p_hold_stable;
    @(posedge clk_in) disable iff (!rst_n_in)
      !load_now |=> $stable(st.hold_id) && $stable(st.hold_par);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("hold register changed without load");

  property p_reset_value;
    @(posedge clk_in)
      !rst_n_in |=> (st.hold_id == 2'h0) && st.hold_par;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("hold register reset value wrong");

  property p_pass_tag;
    @(posedge clk_in) disable iff (!rst_n_in)
      pass_through |=> (request_owner_tag_out == $past(originator_identity_in)) &&
                       (request_owner_tag_parity_out == $past(originator_identity_parity_in));
  endproperty
  a_pass_tag: assert property (p_pass_tag)
    else $error("incoming identity not passed to tag");

  property p_hold_tag;
    @(posedge clk_in) disable iff (!rst_n_in)
      (storage_request_latch_in && !pass_through) |=>
        (request_owner_tag_out == $past(st.hold_id)) && (request_owner_tag_parity_out == $past(st.hold_par));
  endproperty
  a_hold_tag: assert property (p_hold_tag)
    else $error("hold register not driven on ordinary cycle");

  property p_tag_idle;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!storage_request_latch_in && !pass_through) |=> (request_owner_tag_out == 2'h0) &&
                                                        !request_owner_tag_parity_out;
  endproperty
  a_tag_idle: assert property (p_tag_idle)
    else $error("tag active without a storage request");

  property p_remember_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!start_io_in || accept_latch) |=> !remember_latch;
  endproperty
  a_remember_clear: assert property (p_remember_clear)
    else $error("remembered start not cleared");

  property p_seen_sticky;
    @(posedge clk_in) disable iff (!rst_n_in)
      load_now |=> st.load_seen [*1] ##0 (st.load_seen || $past(clear_seen));
  endproperty
  a_seen_sticky: assert property (p_seen_sticky)
    else $error("load indicator lost a load");
endmodule // rit_top
`default_nettype wire

//--- verif/rit_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// processor identity source and storage controller parity check
module rit_far_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // processor side control from the bench
  input wire logic select_in,
  input wire logic [1:0] id_value_in,
  input wire logic bad_parity_in,
  // identity lines toward the channel
  output logic [1:0] identity_out,
  output logic identity_parity_out,
  // tag lines from the channel
  input wire logic [1:0] tag_in,
  input wire logic tag_parity_in,
  output logic tag_parity_ok_out
);
  logic [2:0] last;
  // remember the driven value so released lines never repeat it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last <= 3'h0;
    end else if (select_in) begin
      last <= {identity_parity_out, identity_out};
    end
  end
  // odd parity unless told to lie; released lines show the inverse, not stale data
  always_comb begin
    if (select_in) begin
      identity_out = id_value_in;
      identity_parity_out = ~^id_value_in ^ bad_parity_in;
    end else begin
      {identity_parity_out, identity_out} = ~last;
    end
  end
  // storage controller accepts only odd parity over tag and parity bit
  assign tag_parity_ok_out = ^{tag_parity_in, tag_in};
endmodule // rit_far_model
`default_nettype wire

//--- verif/test_requester_id_tagging.sv
`timescale 1ns/1ns
`default_nettype none
module test_requester_id_tagging;
  logic clk_in, rst_n_in, sel, bad_par, par_ok;
  logic [1:0] idv, originator_identity_in;
  logic originator_identity_parity_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, status_byte_in, inbound_data_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, request_owner_tag_out, condition_code_value_out;
  logic initial_program_load_setup_in, start_io_in, sequence_one_in, sequence_five_in, status_in_in;
  logic timing_pulse_two_in, timing_pulse_four_in, chain_command_first_stage_in;
  logic storage_request_latch_in, interrupt_storage_request_latch_in, logout_inhibit_in, fixed_address_latch_in;
  logic request_owner_tag_parity_out, release_out, identity_load_enable_out;
  int fails, n_tests;

  rit_top rit_top_inst (.clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .originator_identity_in,
    .originator_identity_parity_in, .initial_program_load_setup_in, .start_io_in, .sequence_one_in,
    .sequence_five_in, .status_in_in, .timing_pulse_two_in, .timing_pulse_four_in, .status_byte_in,
    .chain_command_first_stage_in, .inbound_data_in, .storage_request_latch_in,
    .interrupt_storage_request_latch_in, .logout_inhibit_in, .fixed_address_latch_in,
    .request_owner_tag_out, .request_owner_tag_parity_out, .release_out, .condition_code_value_out,
    .identity_load_enable_out);

  rit_far_model rit_far_model_inst (.clk_in, .rst_n_in, .select_in(sel), .id_value_in(idv),
    .bad_parity_in(bad_par), .identity_out(originator_identity_in),
    .identity_parity_out(originator_identity_parity_in), .tag_in(request_owner_tag_out),
    .tag_parity_in(request_owner_tag_parity_out), .tag_parity_ok_out(par_ok));

  // free running clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // look just after an edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic tag_is(input logic [2:0] e);
    chk("tag", {29'h0, e}, {29'h0, request_owner_tag_parity_out, request_owner_tag_out});
  endtask

  // release, condition code and load enable together
  task automatic ans(input logic [3:0] e);
    chk("answer", {28'h0, e}, {28'h0, release_out, condition_code_value_out, identity_load_enable_out});
  endtask

  // one write; valid and payload held until each channel is taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    // no latency assumed: the wait runs until bvalid, bounded only by the watchdog
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, s_axi_bvalid_out, s_axi_bresp_out});
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b0;
    chk("rresp", {29'h0, 1'b1, er}, {29'h0, s_axi_rvalid_out, s_axi_rresp_out});
    chk("rdata", ed, s_axi_rdata_out);
  endtask

  task automatic t_reset;
    ans(4'h0);
    tag_is(3'h0);
    axr(rit_pkg::OFF_STATUS, 32'h4, rit_pkg::RESP_OKAY);
  endtask

  // program load with a deliberately wrong parity, then an ordinary cycle
  task automatic t_program_load;
    @(posedge clk_in);
    sel <= 1'b1;
    idv <= 2'h3;
    bad_par <= 1'b1;
    initial_program_load_setup_in <= 1'b1;
    cyc(1);
    ans(4'h1);
    @(posedge clk_in);
    initial_program_load_setup_in <= 1'b0;
    sel <= 1'b0;
    storage_request_latch_in <= 1'b1;
    cyc(1);
    ans(4'h0);
    tag_is(3'h3);
    chk("tag parity ok", 32'h0, {31'h0, par_ok});
    @(posedge clk_in);
    storage_request_latch_in <= 1'b0;
    cyc(1);
    tag_is(3'h0);
    axr(rit_pkg::OFF_STATUS, 32'hb, rit_pkg::RESP_OKAY);
  endtask

  // logout then status store pass the incoming lines straight through
  task automatic t_pass;
    @(posedge clk_in);
    sel <= 1'b1;
    idv <= 2'h1;
    bad_par <= 1'b0;
    interrupt_storage_request_latch_in <= 1'b1;
    logout_inhibit_in <= 1'b1;
    cyc(1);
    tag_is(3'h1);
    @(posedge clk_in);
    logout_inhibit_in <= 1'b0;
    fixed_address_latch_in <= 1'b1;
    cyc(1);
    tag_is(3'h1);
    @(posedge clk_in);
    interrupt_storage_request_latch_in <= 1'b0;
    fixed_address_latch_in <= 1'b0;
    cyc(1);
    tag_is(3'h0);
    axr(rit_pkg::OFF_STATUS, 32'hb, rit_pkg::RESP_OKAY);
  endtask

  // clean selection blocked by sequence five, then accepted, then load gated by pulse four
  task automatic t_start;
    @(posedge clk_in);
    idv <= 2'h2;
    {start_io_in, sequence_one_in, sequence_five_in, status_in_in, timing_pulse_two_in} <= 5'h1f;
    cyc(2);
    ans(4'h0);
    @(posedge clk_in);
    sequence_five_in <= 1'b0;
    cyc(3);
    ans(4'h9);
    @(posedge clk_in);
    timing_pulse_four_in <= 1'b1;
    cyc(1);
    ans(4'h8);
    axr(rit_pkg::OFF_STATUS, 32'h1a, rit_pkg::RESP_OKAY);
    @(posedge clk_in);
    {start_io_in, sequence_one_in, status_in_in, timing_pulse_two_in, timing_pulse_four_in} <= 5'h0;
    cyc(2);
    ans(4'h0);
  endtask

  task automatic t_regs;
    axw(rit_pkg::OFF_CONTROL, 32'h1, rit_pkg::RESP_OKAY);
    axr(rit_pkg::OFF_STATUS, 32'h2, rit_pkg::RESP_OKAY);
    axw(rit_pkg::OFF_STATUS, 32'hffff_ffff, rit_pkg::RESP_SLVERR);
    axr(rit_pkg::OFF_STATUS, 32'h2, rit_pkg::RESP_OKAY);
    axr(8'h08, 32'h0, rit_pkg::RESP_SLVERR);
    axr(rit_pkg::OFF_CONTROL, 32'h0, rit_pkg::RESP_OKAY);
  endtask

  // command immediate: channel end on inbound bit four
  task automatic t_cmd;
    @(posedge clk_in);
    idv <= 2'h1;
    start_io_in <= 1'b1;
    chain_command_first_stage_in <= 1'b1;
    inbound_data_in <= 8'h10;
    timing_pulse_two_in <= 1'b1;
    cyc(3);
    ans(4'h9);
    axr(rit_pkg::OFF_STATUS, 32'h19, rit_pkg::RESP_OKAY);
    @(posedge clk_in);
    {start_io_in, chain_command_first_stage_in, timing_pulse_two_in} <= 3'h0;
    inbound_data_in <= 8'h00;
    cyc(2);
  endtask

  // start fetch passes incoming lines; after start drops the hold register is used again
  task automatic t_remember;
    @(posedge clk_in);
    idv <= 2'h2;
    start_io_in <= 1'b1;
    storage_request_latch_in <= 1'b1;
    cyc(2);
    tag_is(3'h2);
    @(posedge clk_in);
    start_io_in <= 1'b0;
    cyc(2);
    tag_is(3'h1);
    @(posedge clk_in);
    storage_request_latch_in <= 1'b0;
  endtask

  // main sequence
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, status_byte_in, inbound_data_in} = '0;
    {initial_program_load_setup_in, start_io_in, sequence_one_in, sequence_five_in, status_in_in} = '0;
    {timing_pulse_two_in, timing_pulse_four_in, chain_command_first_stage_in} = '0;
    {storage_request_latch_in, interrupt_storage_request_latch_in, logout_inhibit_in} = '0;
    {fixed_address_latch_in, sel, bad_par, idv, rst_n_in} = '0;
    s_axi_wstrb_in = 4'hf;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cyc(1);
    t_reset();
    t_program_load();
    t_pass();
    t_start();
    t_regs();
    t_cmd();
    t_remember();
    results();
  end

  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // test_requester_id_tagging
`default_nettype wire
